//--- design/gpiolc_pkg.sv
package gpiolc_pkg;

    // ------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------
    localparam int          GPIOLC_LINES   = 32;
    localparam logic [31:0] GPIOLC_ZERO    = 32'h0000_0000;
    localparam logic [31:0] GPIOLC_OWN_RST = 32'hFFFF_FFFF;
    localparam logic [1:0]  GPIOLC_RST_INI = 2'h0;
    localparam logic        GPIOLC_BIT0    = 1'h0;

    typedef logic [GPIOLC_LINES-1:0] gpiolc_word_t;

    // ------------------------------------------------------------
    // one-cycle write strobes, all qualified by wr_data
    // ------------------------------------------------------------
    typedef struct packed {
        logic ctrl_own_enable;
        logic ctrl_own_disable;
        logic periph_a_select_set;
        logic periph_b_select_set;
        logic drive_enable_set;
        logic drive_enable_clear;
        logic out_level_set;
        logic out_level_clear;
        logic out_level_write;
        logic direct_write_mask_set;
        logic direct_write_mask_clear;
        logic open_drain_set;
        logic open_drain_clear;
        logic deglitch_set;
        logic deglitch_clear;
        logic change_irq_enable;
        logic change_irq_disable;
    } gpiolc_wr_s;

    // ------------------------------------------------------------
    // peripheral drive request for all lines
    // ------------------------------------------------------------
    typedef struct packed {
        gpiolc_word_t level;
        gpiolc_word_t enable;
    } gpiolc_drive_s;

endpackage

//--- design/gpiolc_top.sv
`timescale 1ns/1ps

// What this block does
// - a-select write clears, b-select write sets selection; 0 is A, 1 is B.
// - selection steers only output and enable; peripherals always see pin.
// - selection resets to A; lines still reset owned by the controller.
// - selection writes ignore ownership; handover also needs own disable.
// - peripheral-owned line takes drive and enable from selected peripheral.
// - drive enable writes set or clear per-line output enable status.
// - level set/clear writes set or clear the driven output level status.
// - enable and level writes update status even while a peripheral owns pin.
// - direct level write changes only bits whose write mask bit is set.
// - direct write mask resets to all zeros.
// - open-drain set/clear ignores owner; such lines only drive low.
// - open-drain status resets to all zeros.
// - pin level status returns sampled level of every line.
// - with clock stopped, pin level status holds the last sampled levels.
// - filter rejects short glitches, accepts pulses of two cycles or more.
// - filter adds at most one cycle of latency.
// - deglitch set/clear writes set or clear per-line filter status.
// - filter only affects pin level status and change detection.
// - irq enable/disable writes set or clear the change irq mask.
// - change found by comparing two successive samples, for every line.
// - change sets status bit; irq output is OR of masked status bits.
// - reading change status clears all old bits; a change in the same cycle stays set.
// - own enable/disable writes set or clear ownership; 1 is controller.
module gpiolc_top
    import gpiolc_pkg::*;
#(
    parameter gpiolc_word_t OWN_RESET = GPIOLC_OWN_RST
) (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    core_clk_en,
    input  wire logic                    rst_n,
    // software writes and status read
    input  wire gpiolc_pkg::gpiolc_wr_s  wr_cmd,
    input  wire gpiolc_pkg::gpiolc_word_t wr_data,
    input  wire logic                    irq_status_rd,
    // status
    output logic [31:0]                  ctrl_own_status,
    output logic [31:0]                  periph_select_status,
    output logic [31:0]                  drive_enable_status,
    output logic [31:0]                  out_level_status,
    output logic [31:0]                  direct_write_mask_status,
    output logic [31:0]                  open_drain_status,
    output logic [31:0]                  deglitch_status,
    output logic [31:0]                  change_irq_mask,
    output logic [31:0]                  change_irq_status,
    output logic [31:0]                  pin_level_status,
    output logic                         change_irq,
    // peripherals
    input  wire gpiolc_pkg::gpiolc_drive_s periph_a_drive,
    input  wire gpiolc_pkg::gpiolc_drive_s periph_b_drive,
    output logic [31:0]                  periph_a_in,
    output logic [31:0]                  periph_b_in,
    // pins
    input  wire logic [31:0]             pin_in,
    output logic [31:0]                  pin_out,
    output logic [31:0]                  pin_oe
);
    import gpiolc_pkg::*;

    // ------------------------------------------------------------
    // set/clear helper
    // ------------------------------------------------------------
    function automatic gpiolc_word_t setclr(gpiolc_word_t q, logic s,
                                            logic c, gpiolc_word_t d);
        gpiolc_word_t r;
        r = q;
        if (c) begin
            r = r & ~d;
        end
        if (s) begin
            r = r | d;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe_q;
    logic       rst_sync_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= GPIOLC_RST_INI;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_q[1];

    // ------------------------------------------------------------
    // configuration status
    // ------------------------------------------------------------
    gpiolc_word_t own_q, sel_q, drv_q, lvl_q, owm_q, od_q, dg_q, imr_q;
    gpiolc_word_t lvl_d;

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            own_q <= OWN_RESET;
            sel_q <= GPIOLC_ZERO;
        end else if (core_clk_en) begin
            own_q <= setclr(own_q, wr_cmd.ctrl_own_enable,
                            wr_cmd.ctrl_own_disable, wr_data);
            sel_q <= setclr(sel_q, wr_cmd.periph_b_select_set,
                            wr_cmd.periph_a_select_set,
                            wr_data);
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            drv_q <= GPIOLC_ZERO;
            od_q  <= GPIOLC_ZERO;
            owm_q <= GPIOLC_ZERO;
        end else if (core_clk_en) begin
            drv_q <= setclr(drv_q, wr_cmd.drive_enable_set,
                            wr_cmd.drive_enable_clear, wr_data);
            od_q  <= setclr(od_q, wr_cmd.open_drain_set,
                            wr_cmd.open_drain_clear, wr_data);
            owm_q <= setclr(owm_q, wr_cmd.direct_write_mask_set,
                            wr_cmd.direct_write_mask_clear, wr_data);
        end
    end

    // direct write first, then set and clear strobes on top
    always_comb begin
        lvl_d = lvl_q;
        if (wr_cmd.out_level_write) begin
            lvl_d = (lvl_q & ~owm_q) | (wr_data & owm_q);
        end
        lvl_d = setclr(lvl_d, wr_cmd.out_level_set,
                       wr_cmd.out_level_clear, wr_data);
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lvl_q <= GPIOLC_ZERO;
        end else if (core_clk_en) begin
            lvl_q <= lvl_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dg_q  <= GPIOLC_ZERO;
            imr_q <= GPIOLC_ZERO;
        end else if (core_clk_en) begin
            dg_q  <= setclr(dg_q, wr_cmd.deglitch_set,
                            wr_cmd.deglitch_clear, wr_data);
            imr_q <= setclr(imr_q, wr_cmd.change_irq_enable,
                            wr_cmd.change_irq_disable, wr_data);
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    gpiolc_word_t src_lvl, src_en;

    always_comb begin
        src_lvl = (sel_q & periph_b_drive.level)
                | (~sel_q & periph_a_drive.level);
        src_en  = (sel_q & periph_b_drive.enable)
                | (~sel_q & periph_a_drive.enable);
        src_lvl = (own_q & lvl_q) | (~own_q & src_lvl);
        src_en  = (own_q & drv_q) | (~own_q & src_en);
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_out <= GPIOLC_ZERO;
            pin_oe  <= GPIOLC_ZERO;
        end else if (core_clk_en) begin
            // open-drain lines drive low only, else release
            pin_out <= src_lvl & ~od_q;
            pin_oe  <= src_en & ~(od_q & src_lvl);
        end
    end

    // ------------------------------------------------------------
    // input sampling, filtering and change detection
    // ------------------------------------------------------------
    gpiolc_word_t sync1_q, sync2_q, sync3_q, stable_q, stable_prev_q;
    gpiolc_word_t stable_d, filt_d, chg, isr_d;

    // a change counts once second and third stage agree
    assign stable_d = (sync2_q & ~(sync2_q ^ sync3_q))
                    | (stable_q & (sync2_q ^ sync3_q));

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sync1_q       <= GPIOLC_ZERO;
            sync2_q       <= GPIOLC_ZERO;
            sync3_q       <= GPIOLC_ZERO;
            stable_q      <= GPIOLC_ZERO;
            stable_prev_q <= GPIOLC_ZERO;
        end else if (core_clk_en) begin
            sync1_q       <= pin_in;
            sync2_q       <= sync1_q;
            sync3_q       <= sync2_q;
            stable_q      <= stable_d;
            stable_prev_q <= stable_q;
        end
    end

    // filtered lines follow only a level held for two samples
    assign filt_d = (~dg_q & stable_q)
                  | (dg_q & ~(stable_q ^ stable_prev_q) & stable_q)
                  | (dg_q & (stable_q ^ stable_prev_q)
                     & pin_level_status);
    assign chg    = filt_d ^ pin_level_status;
    assign isr_d  = (irq_status_rd ? GPIOLC_ZERO : change_irq_status)
                  | chg;

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_level_status  <= GPIOLC_ZERO;
            change_irq_status <= GPIOLC_ZERO;
            change_irq        <= GPIOLC_BIT0;
            periph_a_in       <= GPIOLC_ZERO;
            periph_b_in       <= GPIOLC_ZERO;
        end else if (core_clk_en) begin
            pin_level_status  <= filt_d;
            change_irq_status <= isr_d;
            change_irq        <= |(isr_d & imr_q);
            periph_a_in       <= stable_q;
            periph_b_in       <= stable_q;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    assign ctrl_own_status          = own_q;
    assign periph_select_status     = sel_q;
    assign drive_enable_status      = drv_q;
    assign out_level_status         = lvl_q;
    assign direct_write_mask_status = owm_q;
    assign open_drain_status        = od_q;
    assign deglitch_status          = dg_q;
    assign change_irq_mask          = imr_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_sel_b_write: assert property (
        @(posedge core_clk) disable iff (!rst_sync_n)
        (core_clk_en && wr_cmd.periph_b_select_set)
        |=> ((periph_select_status & $past(wr_data)) == $past(wr_data)))
        else $error("b-select write did not set selection");

    a_mask_direct: assert property (
        @(posedge core_clk) disable iff (!rst_sync_n)
        (core_clk_en && wr_cmd.out_level_write && !wr_cmd.out_level_set
         && !wr_cmd.out_level_clear)
        |=> (((out_level_status ^ $past(out_level_status))
              & ~$past(owm_q)) == GPIOLC_ZERO))
        else $error("direct write changed an unmasked line");

    a_od_never_high: assert property (
        @(posedge core_clk) disable iff (!rst_sync_n)
        core_clk_en |=> ((pin_oe & pin_out & $past(od_q)) == GPIOLC_ZERO))
        else $error("open-drain line driven high");

    a_ctrl_drive_en: assert property (
        @(posedge core_clk) disable iff (!rst_sync_n)
        core_clk_en |=> (((pin_oe ^ $past(drv_q)) & $past(own_q)
                          & ~$past(od_q)) == GPIOLC_ZERO))
        else $error("owned line enable differs from drive status");

    a_read_clears: assert property (
        @(posedge core_clk) disable iff (!rst_sync_n)
        (core_clk_en && irq_status_rd)
        |=> ((change_irq_status & ~$past(chg)) == GPIOLC_ZERO))
        else $error("status read left old bits set");

    a_change_kept: assert property (
        @(posedge core_clk) disable iff (!rst_sync_n)
        (core_clk_en && chg != GPIOLC_ZERO)
        |=> ((change_irq_status & $past(chg)) == $past(chg)))
        else $error("detected change lost");

    a_irq_or_mask: assert property (
        @(posedge core_clk) disable iff (!rst_sync_n)
        core_clk_en |=> (change_irq
                         == |(change_irq_status & $past(imr_q))))
        else $error("irq output not OR of masked status");

    a_freeze_level: assert property (
        @(posedge core_clk) disable iff (!rst_sync_n)
        !core_clk_en |=> $stable(pin_level_status))
        else $error("pin level changed with clock stopped");

    a_periph_in: assert property (
        @(posedge core_clk) disable iff (!rst_sync_n)
        core_clk_en |=> (periph_a_in == $past(stable_q)
                         && periph_b_in == $past(stable_q)))
        else $error("peripheral input not the unfiltered level");

endmodule

//--- tb/gpiolc_far_side.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// pins with pull-up, outside drivers and two peripherals
// ------------------------------------------------------------
module gpiolc_far_side
    import gpiolc_pkg::*;
(
    // clock
    input  wire logic                      core_clk,
    // bench requests
    input  wire logic [31:0]               ext_en,
    input  wire logic [31:0]               ext_lvl,
    input  wire gpiolc_pkg::gpiolc_drive_s pa_req,
    input  wire gpiolc_pkg::gpiolc_drive_s pb_req,
    // device side
    input  wire logic [31:0]               pin_out,
    input  wire logic [31:0]               pin_oe,
    output gpiolc_pkg::gpiolc_drive_s      pa_drive,
    output gpiolc_pkg::gpiolc_drive_s      pb_drive,
    output logic [31:0]                    pin_in
);
    // peripherals launch their drive on the shared clock
    always_ff @(posedge core_clk) begin
        pa_drive <= pa_req;
        pb_drive <= pb_req;
    end

    // outside driver wins, then the device, then the pull-up
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (ext_en[i])
                pin_in[i] = ext_lvl[i];
            else if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else
                pin_in[i] = 1'b1;
        end
    end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps

module tb;
    import gpiolc_pkg::*;
    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    logic          core_clk      = 1'b0;
    logic          core_clk_en   = 1'b1;
    logic          rst_n         = 1'b0;
    gpiolc_wr_s    wr_cmd        = '0;
    gpiolc_word_t  wr_data       = '0;
    logic          irq_status_rd = 1'b0;
    logic [31:0]   ext_en        = '0;
    logic [31:0]   ext_lvl       = '0;
    gpiolc_drive_s pa_req        = '0;
    gpiolc_drive_s pb_req        = '0;
    gpiolc_drive_s pa_drive, pb_drive;
    logic [31:0]   st [8];
    logic [31:0]   m [8];
    logic [31:0]   pin_lvl, irq_st, pa_in, pb_in, pin_in, pin_out, pin_oe;
    logic [31:0]   istat, last_pin;
    logic          change_irq;
    int            err_total = 0;
    int            tests_run = 0;
    string         nm [8] = '{"own", "sel", "drive_en", "out_level",
                              "wr_mask", "open_drain", "deglitch", "irq_mask"};
    int            seq_i [15] = '{12, 10, 9, 8, 7, 8, 5, 13, 14, 15, 12, 10,
                                  16, 1, 3};
    logic [31:0]   seq_d [15] = '{32'h0000_00FF, 32'h0000_000F, 32'h0000_0003,
        32'hFFFF_FFFF, 32'h0000_00F0, 32'hAAAA_AAAA, 32'h0000_0033,
        32'h0FF0_0000, 32'h00F0_0000, 32'h0FFF_0000, 32'h0F00_0000,
        32'h0F00_0000, 32'h0F00_0000, 32'h0000_FF00, 32'h0000_0100};

    always #50 core_clk = ~core_clk;

    gpiolc_top u_gpiolc_top (.core_clk(core_clk), .core_clk_en(core_clk_en),
        .rst_n(rst_n), .wr_cmd(wr_cmd), .wr_data(wr_data),
        .irq_status_rd(irq_status_rd), .ctrl_own_status(st[0]),
        .periph_select_status(st[1]), .drive_enable_status(st[2]),
        .out_level_status(st[3]), .direct_write_mask_status(st[4]),
        .open_drain_status(st[5]), .deglitch_status(st[6]),
        .change_irq_mask(st[7]), .change_irq_status(irq_st),
        .pin_level_status(pin_lvl), .change_irq(change_irq),
        .periph_a_drive(pa_drive), .periph_b_drive(pb_drive),
        .periph_a_in(pa_in), .periph_b_in(pb_in), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));

    gpiolc_far_side u_gpiolc_far_side (.core_clk(core_clk), .ext_en(ext_en),
        .ext_lvl(ext_lvl), .pa_req(pa_req), .pb_req(pb_req),
        .pin_out(pin_out), .pin_oe(pin_oe), .pa_drive(pa_drive),
        .pb_drive(pb_drive), .pin_in(pin_in));

    // ------------------------------------------------------------
    // expected drive and pin level, {oe, out}
    // ------------------------------------------------------------
    function automatic logic [63:0] exp_drv();
        logic [31:0] oe;
        logic [31:0] lv;
        oe = (m[0] & m[2]) | (~m[0] & ((m[1] & pb_req.enable)
             | (~m[1] & pa_req.enable)));
        lv = (m[0] & m[3]) | (~m[0] & ((m[1] & pb_req.level)
             | (~m[1] & pa_req.level)));
        return {oe & ~(m[5] & lv), lv & ~m[5]};
    endfunction

    function automatic logic [31:0] exp_pin();
        logic [63:0] d;
        d = exp_drv();
        return (ext_en & ext_lvl) | (~ext_en & (d[31:0] | ~d[63:32]));
    endfunction

    // ------------------------------------------------------------
    // compare and transfer tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task automatic regs();
        for (int k = 0; k < 8; k++) chk(nm[k], m[k], st[k]);
    endtask

    // one edge first, so stimulus given by non-blocking update is seen
    task automatic settle();
        logic [31:0] p;
        logic [63:0] d;
        @(posedge core_clk);
        p = exp_pin();
        d = exp_drv();
        istat = istat | (p ^ last_pin);
        last_pin = p;
        repeat (7) @(posedge core_clk);
        #1;
        regs();
        chk("pin_oe", d[63:32], pin_oe);
        chk("pin_out", d[31:0], pin_out);
        chk("pin_level", p, pin_lvl);
        chk("periph_a_in", p, pa_in);
        chk("periph_b_in", p, pb_in);
        chk("irq_status", istat, irq_st);
        chk("irq", {31'h0, |(istat & m[7])}, {31'h0, change_irq});
    endtask

    task automatic wr(input int i, input logic [31:0] d);
        @(posedge core_clk);
        wr_cmd <= gpiolc_wr_s'(17'h1 << i);
        wr_data <= d;
        @(posedge core_clk);
        wr_cmd <= '0;
        case (i)
            16: m[0] = m[0] | d;
            15: m[0] = m[0] & ~d;
            14: m[1] = m[1] & ~d;
            13: m[1] = m[1] | d;
            12: m[2] = m[2] | d;
            11: m[2] = m[2] & ~d;
            10: m[3] = m[3] | d;
            9: m[3] = m[3] & ~d;
            8: m[3] = (m[3] & ~m[4]) | (d & m[4]);
            7: m[4] = m[4] | d;
            6: m[4] = m[4] & ~d;
            5: m[5] = m[5] | d;
            4: m[5] = m[5] & ~d;
            3: m[6] = m[6] | d;
            2: m[6] = m[6] & ~d;
            1: m[7] = m[7] | d;
            default: m[7] = m[7] & ~d;
        endcase
        #1;
        regs();
        settle();
    endtask

    task automatic rd();
        @(posedge core_clk);
        irq_status_rd <= 1'b1;
        #1;
        chk("irq_status_read", istat, irq_st);
        istat = '0;
        @(posedge core_clk);
        irq_status_rd <= 1'b0;
        settle();
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h76ccbd57));
        pa_req = {$urandom(), $urandom()};
        pb_req = {$urandom(), $urandom()};
        for (int k = 0; k < 8; k++) m[k] = '0;
        m[0] = GPIOLC_OWN_RST;
        istat = '0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        regs();
        chk("pin_oe_reset", '0, pin_oe);
        repeat (10) @(posedge core_clk);
        irq_status_rd <= 1'b1;
        @(posedge core_clk);
        irq_status_rd <= 1'b0;
        last_pin = exp_pin();
        settle();
        for (int k = 0; k < 15; k++) wr(seq_i[k], seq_d[k]);
        ext_en <= 32'h0000_FFFF;
        ext_lvl <= 32'h0000_0F0F;
        settle();
        rd();
        // short glitch straddling an edge on a filtered line
        @(posedge core_clk);
        #70;
        ext_lvl[8] = ~ext_lvl[8];
        #40;
        ext_lvl[8] = ~ext_lvl[8];
        settle();
        ext_lvl <= ext_lvl ^ 32'h0000_0100;
        settle();
        rd();
        // stopped clock: writes and sampling frozen
        core_clk_en <= 1'b0;
        ext_lvl <= ext_lvl ^ 32'h0000_FF00;
        wr_cmd <= gpiolc_wr_s'(17'h1 << 16);
        wr_data <= '1;
        @(posedge core_clk);
        wr_cmd <= '0;
        repeat (8) @(posedge core_clk);
        #1;
        regs();
        chk("pin_level_frozen", last_pin, pin_lvl);
        @(posedge core_clk);
        core_clk_en <= 1'b1;
        settle();
        for (int n = 0; n < 150; n++) begin
            int r;
            r = $urandom_range(19, 0);
            if (r < 17) begin
                wr(r, $urandom());
            end else if (r == 17) begin
                pa_req <= {$urandom(), $urandom()};
                pb_req <= {$urandom(), $urandom()};
                settle();
            end else if (r == 18) begin
                ext_en <= $urandom();
                ext_lvl <= $urandom();
                settle();
            end else begin
                rd();
            end
        end
        results();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        results();
    end
endmodule
